// >>> dcs_pkg.sv
// Purpose: shared constants of the debug communication status block
// Assumes: 32-bit internal system bus, byte addresses
// Notes:   offsets are relative to the module base address
package dcs_pkg;
   // address map
   localparam logic [31:0] DCS_BASE_ADDR = 32'hf000_0400;
   localparam logic [31:0] DCS_END_ADDR  = 32'hf000_04ff;
   localparam logic [31:0] OFS_COMM_DATA = 32'h0000_0068;
   localparam logic [31:0] OFS_STATUS    = 32'h0000_006c;

   // status/control register fields
   localparam int STS_RW_DIS    = 0;
   localparam int STS_RW_DIS_WP = 1;
   localparam int STS_SEC       = 2;
   localparam int STS_SEC_WP    = 3;
   localparam int STS_RD_REQ    = 4;
   localparam int STS_WR_OFFER  = 5;
   localparam int STS_ACK       = 6;
   localparam int STS_HL_SYNC   = 7;
   localparam int STS_DBG_ON    = 8;
   localparam int STS_CLIENT    = 9;
   localparam int STS_CHAN_LO   = 12;
   localparam int CHAN_W        = 3;

   // jtag configuration word fields
   localparam int CFG_W        = 12;
   localparam int CFG_MODE     = 0;
   localparam int CFG_ABORT    = 1;
   localparam int CFG_SYNC_SET = 2;
   localparam int CFG_CHAN_LO  = 8;

   localparam int TRACE_W = 8;

   // reset values
   localparam logic              RST_FLAG      = 1'b0;
   localparam logic              RST_MODE_RW   = 1'b0;
   localparam logic [CHAN_W-1:0] RST_CHAN      = 3'h0;
   localparam logic [7:0]        RST_TRACE     = 8'h00;
   localparam logic [31:0]       RST_WORD      = 32'h0000_0000;

   // synchroniser lanes
   localparam int SYN_DBG    = 0;
   localparam int SYN_CLIENT = 1;
   localparam int SYN_CFG    = 2;
   localparam int SYN_OFFER  = 3;
   localparam int SYN_REQ    = 4;
   localparam int SYN_TRACE  = 5;
   localparam int SYN_W      = 6;
endpackage

// >>> dcs_sync_if.sv
// Purpose: carries synchronised levels from the synchroniser to the core
// Assumes: single clock domain on the consumer side
// Notes:   producer drives, consumer only reads
interface dcs_sync_if #(parameter int W = 6);
   logic [W-1:0] q;
   modport prod (output q);
   modport cons (input  q);
endinterface

// >>> dcs_sync.sv
// Purpose: two-flop synchroniser for a bundle of independent levels
// Assumes: each lane is a level or a toggle, never a multi-bit word
// Notes:   first stage is read by the second stage only
module dcs_sync #(
   parameter int W = 6
) (
   // clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         arst_n_i,
   // raw levels from the jtag side
   input  wire logic [W-1:0] d_i,
   // synchronised levels
   dcs_sync_if.prod          sync
);
   logic [W-1:0] meta;
   logic [W-1:0] stable;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta   <= '0;
         stable <= '0;
      end else begin
         meta   <= d_i;
         stable <= meta;
      end
   end

   assign sync.q = stable;
endmodule

// >>> dcs_top.sv
// Purpose: debug communication status/control and trace address logic
// Assumes: jtag words are held stable from toggle until it is seen here
// Notes:   bus answer one cycle after a selected in-window access
////////////////////////////////////////////////////////////////////////////

// Functional notes
// (R1) bit 0: 1 disables read/write debug access
// (R2) bit 0 changes only with bit 1 set
// (R3) bit 0 writable only in communication mode
// (R4) bit 0 writable only by supervisor transfers
// (R5) security bit 2 cleared by jtag reset only; code also clears it on a bus write with bit 3 set and bit 2 at 0
// (R6) bit 2 changes only with bit 3 set
// (R7) bit 4 shows pending debugger read request
// (R8) bit 5 shows pending debugger value offer
// (R9) monitor writes bit 6 after reading offer
// (R10) bit 7 sync flag, hardware updated only
// (R11) bit 8 shows external debugger present
// (R12) bit 9 shows this client selected
// (R13) bits 14:12 show addressed monitor channel
// (R14) status register reached from system bus only
// (R15) trace register gives top 8 address bits
// (R16) only jtag instruction loads trace register
// (R17) registers decode in 256-byte window at base
// (R18) register address is base plus offset
// (R19) config write with set bit sets sync
// (R20) config abort clears pending offer once
// (R21) config mode bit: 0 comm, 1 rw
// (R22) acknowledge clears pending offer flag
// (R23) implemented bits reset 0, reserved read 0
module dcs_top
   import dcs_pkg::*;
#(
   parameter logic [31:0] BASE_ADDR = DCS_BASE_ADDR
) (
   // clock and resets
   input  wire logic               core_clk_i,
   input  wire logic               arst_n_i,
   input  wire logic               jtag_rst_n_i,
   // internal system bus slave
   input  wire logic               sb_sel_i,
   input  wire logic               sb_wr_i,
   input  wire logic               sb_sv_i,
   input  wire logic [31:0]        sb_addr_i,
   input  wire logic [31:0]        sb_wdata_i,
   output logic                    sb_ack_o,
   output logic [31:0]             sb_rdata_o,
   // jtag side, levels and toggles
   input  wire logic               jtag_dbg_present_i,
   input  wire logic               jtag_client_sel_i,
   input  wire logic               jtag_cfg_tgl_i,
   input  wire logic [CFG_W-1:0]   jtag_cfg_word_i,
   input  wire logic               jtag_offer_tgl_i,
   input  wire logic [31:0]        jtag_offer_data_i,
   input  wire logic               jtag_req_tgl_i,
   input  wire logic               jtag_trace_tgl_i,
   input  wire logic [TRACE_W-1:0] jtag_trace_addr_i,
   // state toward the debug unit
   output logic                    comm_mode_rw_o,
   output logic                    rw_disable_o,
   output logic                    security_o,
   output logic                    read_request_pending_o,
   output logic                    write_offer_pending_o,
   output logic                    high_level_sync_o,
   output logic [31:0]             comm_data_o,
   output logic [TRACE_W-1:0]      trace_address_high_o,
   output logic [CHAN_W-1:0]       addressed_monitor_channel_o
);
   ////////////////////////////////////////////////////////////////////////
   // state
   logic                mode_rw;
   logic                rw_mode_disable_flag;
   logic                security_flag;
   logic                read_request_pending;
   logic                write_offer_pending;
   logic                high_level_sync_flag;
   logic                debugger_present;
   logic                client_selected;
   logic [CHAN_W-1:0]   addressed_monitor_channel;
   logic [TRACE_W-1:0]  trace_address_high;
   logic [31:0]         comm_data_register;
   logic [3:0]          tgl_prev;

   ////////////////////////////////////////////////////////////////////////
   // jtag side crossing
   dcs_sync_if #(.W(SYN_W)) sif ();

   dcs_sync #(.W(SYN_W)) u_sync (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .d_i        ({jtag_trace_tgl_i, jtag_req_tgl_i, jtag_offer_tgl_i,
                    jtag_cfg_tgl_i, jtag_client_sel_i,
                    jtag_dbg_present_i}),
      .sync       (sif)
   );

   logic cfg_evt;
   logic offer_evt;
   logic req_evt;
   logic trace_evt;

   assign cfg_evt   = sif.q[SYN_CFG]   ^ tgl_prev[0];
   assign offer_evt = sif.q[SYN_OFFER] ^ tgl_prev[1];
   assign req_evt   = sif.q[SYN_REQ]   ^ tgl_prev[2];
   assign trace_evt = sif.q[SYN_TRACE] ^ tgl_prev[3];

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tgl_prev <= '0;
      end else begin
         tgl_prev <= sif.q[SYN_TRACE:SYN_CFG];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   logic in_win;
   logic hit_status;
   logic hit_comm;
   logic wr_status;
   logic wr_comm;
   logic rw_dis_we;
   logic sec_we;
   logic ack_we;

   assign in_win     = sb_addr_i[31:8] == BASE_ADDR[31:8];        // [R17]
   assign hit_status = sb_addr_i == BASE_ADDR + OFS_STATUS;       // [R18] [R14]
   assign hit_comm   = sb_addr_i == BASE_ADDR + OFS_COMM_DATA;    // [R18]
   assign wr_status  = sb_sel_i & sb_wr_i & hit_status;
   assign wr_comm    = sb_sel_i & sb_wr_i & hit_comm;
   assign rw_dis_we  = wr_status & sb_wdata_i[STS_RW_DIS_WP]      // [R2]
                       & ~mode_rw                                 // [R3]
                       & sb_sv_i;                                 // [R4]
   assign sec_we     = wr_status & sb_wdata_i[STS_SEC_WP];        // [R6]
   assign ack_we     = wr_status & sb_wdata_i[STS_ACK];           // [R9]

   ////////////////////////////////////////////////////////////////////////
   // protection and security flags
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rw_mode_disable_flag <= RST_FLAG;                         // [R23]
      end else if (rw_dis_we) begin
         rw_mode_disable_flag <= sb_wdata_i[STS_RW_DIS];           // [R1]
      end
   end

   // survives cpu and bus reset
   always_ff @(posedge core_clk_i or negedge jtag_rst_n_i) begin
      if (!jtag_rst_n_i) begin
         security_flag <= RST_FLAG;                                // [R5]
      end else if (sec_we) begin
         security_flag <= sb_wdata_i[STS_SEC];                     // [R6]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // jtag configuration
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_rw                   <= RST_MODE_RW;
         addressed_monitor_channel <= RST_CHAN;
      end else if (cfg_evt) begin
         mode_rw                   <= jtag_cfg_word_i[CFG_MODE];   // [R21]
         addressed_monitor_channel <=
            jtag_cfg_word_i[CFG_CHAN_LO +: CHAN_W];                // [R13]
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trace_address_high <= RST_TRACE;
      end else if (trace_evt) begin
         trace_address_high <= jtag_trace_addr_i;                  // [R15] [R16]
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         debugger_present <= RST_FLAG;
         client_selected  <= RST_FLAG;
      end else begin
         debugger_present <= sif.q[SYN_DBG];                       // [R11]
         client_selected  <= sif.q[SYN_CLIENT];                    // [R12]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // communication handshake, set wins over clear
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         write_offer_pending <= RST_FLAG;
      end else if (offer_evt) begin
         write_offer_pending <= 1'b1;                              // [R8]
      end else if (ack_we) begin
         write_offer_pending <= 1'b0;                              // [R22]
      end else if (cfg_evt && jtag_cfg_word_i[CFG_ABORT]) begin
         write_offer_pending <= 1'b0;                              // [R20]
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         high_level_sync_flag <= RST_FLAG;
      end else if (cfg_evt && jtag_cfg_word_i[CFG_SYNC_SET]) begin
         high_level_sync_flag <= 1'b1;                             // [R19] [R10]
      end else if (cfg_evt && jtag_cfg_word_i[CFG_ABORT]) begin
         high_level_sync_flag <= 1'b0;                             // [R10]
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         read_request_pending <= RST_FLAG;
      end else if (req_evt) begin
         read_request_pending <= 1'b1;                             // [R7]
      end else if (wr_comm) begin
         read_request_pending <= 1'b0;                             // [R7]
      end
   end

   // jtag offer wins a same-cycle collision
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         comm_data_register <= RST_WORD;
      end else if (offer_evt) begin
         comm_data_register <= jtag_offer_data_i;
      end else if (wr_comm) begin
         comm_data_register <= sb_wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus read path
   logic [31:0] status_word;
   logic [31:0] next_rdata;

   always_comb begin
      status_word                           = RST_WORD;            // [R23]
      status_word[STS_RW_DIS]               = rw_mode_disable_flag;
      status_word[STS_SEC]                  = security_flag;
      status_word[STS_RD_REQ]               = read_request_pending;
      status_word[STS_WR_OFFER]             = write_offer_pending;
      status_word[STS_HL_SYNC]              = high_level_sync_flag;
      status_word[STS_DBG_ON]               = debugger_present;
      status_word[STS_CLIENT]               = client_selected;
      status_word[STS_CHAN_LO +: CHAN_W]    = addressed_monitor_channel;
   end

   always_comb begin
      next_rdata = RST_WORD;
      if (sb_sel_i && !sb_wr_i) begin
         if (hit_status) begin
            next_rdata = status_word;                              // [R14]
         end else if (hit_comm) begin
            next_rdata = comm_data_register;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sb_ack_o   <= 1'b0;
         sb_rdata_o <= RST_WORD;
      end else begin
         sb_ack_o   <= sb_sel_i & in_win;                          // [R17]
         sb_rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         comm_mode_rw_o              <= RST_MODE_RW;
         rw_disable_o                <= RST_FLAG;
         read_request_pending_o      <= RST_FLAG;
         write_offer_pending_o       <= RST_FLAG;
         high_level_sync_o           <= RST_FLAG;
         comm_data_o                 <= RST_WORD;
         trace_address_high_o        <= RST_TRACE;
         addressed_monitor_channel_o <= RST_CHAN;
      end else begin
         comm_mode_rw_o              <= mode_rw;
         rw_disable_o                <= rw_mode_disable_flag;
         read_request_pending_o      <= read_request_pending;
         write_offer_pending_o       <= write_offer_pending;
         high_level_sync_o           <= high_level_sync_flag;
         comm_data_o                 <= comm_data_register;
         trace_address_high_o        <= trace_address_high;
         addressed_monitor_channel_o <= addressed_monitor_channel;
      end
   end

   always_ff @(posedge core_clk_i or negedge jtag_rst_n_i) begin
      if (!jtag_rst_n_i) begin
         security_o <= RST_FLAG;
      end else begin
         security_o <= security_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_rw_dis_protect;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      $changed(rw_mode_disable_flag) |->
         $past(wr_status && sb_wdata_i[STS_RW_DIS_WP]);
   endproperty
   a_rw_dis_protect: assert property (p_rw_dis_protect) // [R2]
      else $error("run mode disable changed without protect bit");

   property p_rw_dis_comm_only;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      $changed(rw_mode_disable_flag) |-> !$past(mode_rw);
   endproperty
   a_rw_dis_comm_only: assert property (p_rw_dis_comm_only) // [R3]
      else $error("disable flag changed in rw mode");

   property p_rw_dis_sv_only;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (wr_status && !sb_sv_i) |=> $stable(rw_mode_disable_flag);
   endproperty
   a_rw_dis_sv_only: assert property (p_rw_dis_sv_only) // [R4]
      else $error("user write changed disable flag");

   property p_sec_protect;
      @(posedge core_clk_i) disable iff (!jtag_rst_n_i)
      (wr_status && sb_wdata_i[STS_SEC_WP]) |=>
         security_flag == $past(sb_wdata_i[STS_SEC]);
   endproperty
   a_sec_protect: assert property (p_sec_protect) // [R6]
      else $error("security flag not loaded by protected write");

   property p_sec_hold;
      @(posedge core_clk_i) disable iff (!jtag_rst_n_i)
      !sec_we |=> $stable(security_flag);
   endproperty
   a_sec_hold: assert property (p_sec_hold) // [R5]
      else $error("security flag changed without jtag reset or write");

   property p_offer_set;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      offer_evt |=> write_offer_pending ##1 write_offer_pending_o;
   endproperty
   a_offer_set: assert property (p_offer_set) // [R8]
      else $error("offer did not raise pending flag");

   property p_ack_clear;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (ack_we && !offer_evt) |=> !write_offer_pending;
   endproperty
   a_ack_clear: assert property (p_ack_clear) // [R22]
      else $error("acknowledge did not clear offer flag");

   property p_abort_clear;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (cfg_evt && jtag_cfg_word_i[CFG_ABORT] && !offer_evt) |=>
         !write_offer_pending;
   endproperty
   a_abort_clear: assert property (p_abort_clear) // [R20]
      else $error("abort did not clear offer flag");

   property p_sync_set;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      (cfg_evt && jtag_cfg_word_i[CFG_SYNC_SET]) |=>
         high_level_sync_flag ##1 high_level_sync_o;
   endproperty
   a_sync_set: assert property (p_sync_set) // [R19]
      else $error("config set did not raise sync flag");

   property p_chan_load;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      cfg_evt |=> addressed_monitor_channel ==
         $past(jtag_cfg_word_i[CFG_CHAN_LO +: CHAN_W]);
   endproperty
   a_chan_load: assert property (p_chan_load) // [R13]
      else $error("channel not loaded from config word");

   property p_trace_load;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      trace_evt |=> ##1 trace_address_high_o == $past(jtag_trace_addr_i, 2);
   endproperty
   a_trace_load: assert property (p_trace_load) // [R15]
      else $error("trace address not loaded");

   property p_reserved_zero;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      $past(sb_sel_i && !sb_wr_i && hit_status) |->
         sb_ack_o && sb_rdata_o[31:15] == '0 && sb_rdata_o[11:10] == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // [R23]
      else $error("reserved status bits read nonzero");

   c_offer_ack: cover property (@(posedge core_clk_i) disable iff
      (!arst_n_i) offer_evt ##[1:20] ack_we);
   c_req_answer: cover property (@(posedge core_clk_i) disable iff
      (!arst_n_i) req_evt ##[1:20] wr_comm);
   c_protect_write: cover property (@(posedge core_clk_i) disable iff
      (!arst_n_i) rw_dis_we && sb_wdata_i[STS_RW_DIS]);
   c_cfg_sync: cover property (@(posedge core_clk_i) disable iff
      (!arst_n_i) cfg_evt && jtag_cfg_word_i[CFG_SYNC_SET]);
endmodule

// >>> dcs_jtag_model.sv
// Purpose: debugger side model driving jtag events into the block
// Assumes: events spaced well beyond the synchroniser depth
// Notes:   words held six cycles after each toggle, then scrambled
module dcs_jtag_model
   import dcs_pkg::*;
(
   // clock
   input  wire logic          core_clk_i,
   // jtag levels and toggles
   output logic               jtag_rst_n_o,
   output logic               dbg_o,
   output logic               client_o,
   output logic               cfg_tgl_o,
   output logic [CFG_W-1:0]   cfg_word_o,
   output logic               offer_tgl_o,
   output logic [31:0]        offer_data_o,
   output logic               req_tgl_o,
   output logic               trace_tgl_o,
   output logic [TRACE_W-1:0] trace_addr_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      jtag_rst_n_o = 1'b0;
      dbg_o        = 1'b0;
      client_o     = 1'b0;
      cfg_tgl_o    = 1'b0;
      cfg_word_o   = 12'h000;
      offer_tgl_o  = 1'b0;
      offer_data_o = 32'h0;
      req_tgl_o    = 1'b0;
      trace_tgl_o  = 1'b0;
      trace_addr_o = 8'h00;
      repeat (3) @(negedge core_clk_i);
      jtag_rst_n_o = 1'b1;
   end

   ////////////////////////////////////////
   task automatic hold();
      repeat (6) @(negedge core_clk_i);
   endtask

   task automatic jrst();
      @(negedge core_clk_i);
      jtag_rst_n_o = 1'b0;
      @(negedge core_clk_i);
      jtag_rst_n_o = 1'b1;
   endtask

   task automatic lvl(input logic d, input logic c);
      @(negedge core_clk_i);
      dbg_o    = d;
      client_o = c;
      hold();
   endtask

   task automatic cfg(input logic [CFG_W-1:0] w);
      @(negedge core_clk_i);
      cfg_word_o = w;
      cfg_tgl_o  = ~cfg_tgl_o;
      hold();
      cfg_word_o = ~w;
   endtask

   task automatic offer(input logic [31:0] d);
      @(negedge core_clk_i);
      offer_data_o = d;
      offer_tgl_o  = ~offer_tgl_o;
      hold();
      offer_data_o = ~d;
   endtask

   task automatic req();
      @(negedge core_clk_i);
      req_tgl_o = ~req_tgl_o;
      hold();
   endtask

   // only the jtag instruction path loads the trace address
   task automatic trace(input logic [TRACE_W-1:0] a);
      @(negedge core_clk_i);
      trace_addr_o = a;
      trace_tgl_o  = ~trace_tgl_o;
      hold();
      trace_addr_o = ~a;
   endtask
endmodule

// >>> dcs_top_test.sv
// Purpose: self-checking bench of the debug comm status block
// Assumes: bus answer registered at the taking edge, checked at the next falling edge
// Notes:   inputs change at the falling edge
module dcs_top_test
   import dcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] st = DCS_BASE_ADDR + OFS_STATUS;
   localparam logic [31:0] cd = DCS_BASE_ADDR + OFS_COMM_DATA;
   logic               core_clk_i = 1'b0, arst_n_i;
   logic               sb_sel_i, sb_wr_i, sb_sv_i;
   logic [31:0]        sb_addr_i, sb_wdata_i;
   logic               jtag_rst_n_i, jtag_dbg_present_i, jtag_client_sel_i;
   logic               jtag_cfg_tgl_i, jtag_offer_tgl_i, jtag_req_tgl_i;
   logic               jtag_trace_tgl_i, sb_ack_o, comm_mode_rw_o;
   logic               rw_disable_o, security_o, high_level_sync_o;
   logic               read_request_pending_o, write_offer_pending_o;
   logic [CFG_W-1:0]   jtag_cfg_word_i;
   logic [31:0]        jtag_offer_data_i, comm_data_o, sb_rdata_o;
   logic [TRACE_W-1:0] jtag_trace_addr_i, trace_address_high_o;
   logic [CHAN_W-1:0]  addressed_monitor_channel_o;
   int                 bad_count = 0, compares = 0;

   always #4 core_clk_i = ~core_clk_i;

   dcs_top i_dcs_top (.core_clk_i, .arst_n_i, .jtag_rst_n_i, .sb_sel_i,
      .sb_wr_i, .sb_sv_i, .sb_addr_i, .sb_wdata_i, .sb_ack_o, .sb_rdata_o,
      .jtag_dbg_present_i, .jtag_client_sel_i, .jtag_cfg_tgl_i,
      .jtag_cfg_word_i, .jtag_offer_tgl_i, .jtag_offer_data_i,
      .jtag_req_tgl_i, .jtag_trace_tgl_i, .jtag_trace_addr_i,
      .comm_mode_rw_o, .rw_disable_o, .security_o, .read_request_pending_o,
      .write_offer_pending_o, .high_level_sync_o, .comm_data_o,
      .trace_address_high_o, .addressed_monitor_channel_o);

   dcs_jtag_model i_dcs_jtag_model (.core_clk_i,
      .jtag_rst_n_o(jtag_rst_n_i), .dbg_o(jtag_dbg_present_i),
      .client_o(jtag_client_sel_i), .cfg_tgl_o(jtag_cfg_tgl_i),
      .cfg_word_o(jtag_cfg_word_i), .offer_tgl_o(jtag_offer_tgl_i),
      .offer_data_o(jtag_offer_data_i), .req_tgl_o(jtag_req_tgl_i),
      .trace_tgl_o(jtag_trace_tgl_i), .trace_addr_o(jtag_trace_addr_i));

   ////////////////////////////////////////
   task automatic stop_test();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkf(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic acc(input logic w, input logic s, input logic [31:0] a,
                      input logic [31:0] d, input logic ek);
      @(negedge core_clk_i);
      sb_sel_i   = 1'b1;
      sb_wr_i    = w;
      sb_sv_i    = s;
      sb_addr_i  = a;
      sb_wdata_i = d;
      @(negedge core_clk_i);
      sb_sel_i = 1'b0;
      chkf(sb_ack_o, ek);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d,
                     input logic s);
      acc(1'b1, s, a, d, 1'b1);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e,
                     input logic ek);
      acc(1'b0, 1'b1, a, 32'h0, ek);
      chk(sb_rdata_o, e);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk_i);
      bad_count++;
      stop_test();
   end

   ////////////////////////////////////////
   initial begin
      arst_n_i   = 1'b0;
      sb_sel_i   = 1'b0;
      sb_wr_i    = 1'b0;
      sb_sv_i    = 1'b0;
      sb_addr_i  = 32'h0;
      sb_wdata_i = 32'h0;
      repeat (10) @(negedge core_clk_i);
      arst_n_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      rd(st, 32'h0, 1'b1);
      chk(trace_address_high_o, 8'h00);
      i_dcs_jtag_model.lvl(1'b1, 1'b1);
      i_dcs_jtag_model.cfg(12'h500);
      rd(st, 32'h5300, 1'b1);
      $display("test status end");
      wr(st, 32'h1, 1'b1);
      wr(st, 32'h3, 1'b0);
      rd(st, 32'h5300, 1'b1);
      wr(st, 32'h3, 1'b1);
      rd(st, 32'h5301, 1'b1);
      chkf(rw_disable_o, 1'b1);
      i_dcs_jtag_model.cfg(12'h501);
      chkf(comm_mode_rw_o, 1'b1);
      wr(st, 32'h2, 1'b1);
      rd(st, 32'h5301, 1'b1);
      i_dcs_jtag_model.cfg(12'h500);
      wr(st, 32'h2, 1'b1);
      rd(st, 32'h5300, 1'b1);
      $display("test protect end");
      wr(st, 32'h4, 1'b0);
      rd(st, 32'h5300, 1'b1);
      wr(st, 32'hc, 1'b0);
      rd(st, 32'h5304, 1'b1);
      // even toggle count: release sees no stale config event
      i_dcs_jtag_model.cfg(12'h500);
      @(negedge core_clk_i);
      arst_n_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      arst_n_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      rd(st, 32'h0304, 1'b1);
      chkf(security_o, 1'b1);
      chkf(comm_mode_rw_o, 1'b0);
      i_dcs_jtag_model.jrst();
      rd(st, 32'h0300, 1'b1);
      i_dcs_jtag_model.cfg(12'h500);
      chk(addressed_monitor_channel_o, 32'h5);
      $display("test security end");
      i_dcs_jtag_model.offer(32'ha5c3_1e07);
      rd(st, 32'h5320, 1'b1);
      chkf(write_offer_pending_o, 1'b1);
      rd(cd, 32'ha5c3_1e07, 1'b1);
      chk(comm_data_o, 32'ha5c3_1e07);
      wr(st, 32'h0, 1'b1);
      rd(st, 32'h5320, 1'b1);
      wr(st, 32'h40, 1'b1);
      rd(st, 32'h5300, 1'b1);
      i_dcs_jtag_model.req();
      rd(st, 32'h5310, 1'b1);
      chkf(read_request_pending_o, 1'b1);
      wr(cd, 32'h0, 1'b1);
      rd(st, 32'h5300, 1'b1);
      $display("test handshake end");
      i_dcs_jtag_model.cfg(12'h504);
      rd(st, 32'h5380, 1'b1);
      wr(st, 32'h0, 1'b1);
      rd(st, 32'h5380, 1'b1);
      chkf(high_level_sync_o, 1'b1);
      i_dcs_jtag_model.offer(32'h0f0f_1234);
      rd(st, 32'h53a0, 1'b1);
      i_dcs_jtag_model.cfg(12'h502);
      rd(st, 32'h5300, 1'b1);
      $display("test sync end");
      i_dcs_jtag_model.trace(8'h9c);
      chk(trace_address_high_o, 8'h9c);
      wr(DCS_BASE_ADDR, 32'hffff_ffff, 1'b1);
      chk(trace_address_high_o, 8'h9c);
      rd(DCS_BASE_ADDR + 32'h10, 32'h0, 1'b1);
      rd(DCS_END_ADDR, 32'h0, 1'b1);
      rd(DCS_END_ADDR + 32'h1, 32'h0, 1'b0);
      rd(DCS_BASE_ADDR - 32'h1, 32'h0, 1'b0);
      wr(st, 32'hffff_ffff, 1'b1);
      rd(st, 32'h5305, 1'b1);
      $display("test map end");
      stop_test();
   end
endmodule
